// file: hw/disk_ctrl_host_io_port.sv
/*
  Host byte port of the disk controller: I/O decode at the switch base,
  strobe qualification, handshake, command collection, sector buffer,
  soft and hardware clear, and vectored interrupt drive.
  Assumes all bus pins, switches and jumpers are asynchronous and pass
  through pin_sync; the drive side is stood in for by the sector buffer.
*/
`timescale 1ns/10ps
// Notes on behaviour
// - Port group decodes at six-switch base 04..FC, switch one lowest.
// - Interrupt drives exactly one of V0..V7, chosen by strap.
// - Hardware clear comes from power-on clear or slave clear per jumper.
// - Writes qualified by output status alone, or with write strobe.
// - Reads qualified by input status alone, or with read strobe.
// - Strap fitted gives 256-byte, 32-sector tracks; absent gives 512, 17.
// - All traffic is bytes at base plus offsets zero to three.
// - New command only while idle; busy until the command finishes.
// - Offset zero read gives sector data or the single status byte.
// - Offset one read gives handshake: out ready, in ready, busy.
// - With receive enable set, input ready raises the interrupt.
// - With completion enable set, not busy raises the interrupt.
// - Offset zero writes carry data or commands; commands are eight bytes.
// - Offset one write starts a command, then eight bytes, busy, execute.
// - Offset two write or power-up clears the controller.
// - Any clear disables both interrupt enables.
// - Offset three write loads enables: bit 0 completion, bit 1 receive.
// - A pending interrupt goes away when its cause or its enable is cleared.
// - Status command returns exactly one status byte of the last task.
// - After clear or diagnostic, no interleave until set-interleave runs.
module disk_ctrl_host_io_port #(
  parameter int EXEC_CYCLES = disk_port_pkg::EXEC_CYCLES_DEF
) (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // Host bus address, data and status.
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_dbo,
  input wire logic i_sout,
  input wire logic i_sinp,
  input wire logic i_pwr_n,
  input wire logic i_pdbin,
  input wire logic i_poc_n,
  input wire logic i_slave_clr_n,
  // Switches and jumpers.
  input wire logic [5:0] i_base_sw,
  input wire logic [2:0] i_prio_sel,
  input wire logic i_reset_source_jumper,
  input wire logic i_write_qualify_jumper,
  input wire logic i_read_qualify_jumper,
  input wire logic i_sector_size_strap,
  // Host read data and interrupt line enables.
  output logic [7:0] o_dbi,
  output logic o_dbi_oe,
  output logic [7:0] o_vint_oe
);
  import disk_port_pkg::*;

  localparam int SW = 35;
  localparam logic [15:0] EXEC_LAST = 16'(EXEC_CYCLES - 1);

  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins;
  logic [7:0] addr;
  logic [7:0] dbo;
  logic sout, sinp, pwr_n, pdbin, poc_n, slave_clr_n;
  logic [5:0] base_sw;
  logic [2:0] prio;
  logic rs_jmp, wq_jmp, rq_jmp, ss_strap;
  logic hit, wr_q, rd_q, wr_hit, rd_hit;
  logic wr_act, rd_act, wr_evt, rd_evt;
  logic [1:0] wr_ofs, rd_ofs;
  logic [7:0] wr_data;
  logic data_wr, start_wr, data_rd;
  logic soft_clr, hw_clr, core_clr;
  logic [1:0] ien;
  ctl_state_type state;
  logic [9:0] cnt, xfer_len, sect_len, spt;
  logic [15:0] exec_cnt;
  logic [3:0] cmd_code;
  logic busy, out_rdy, in_rdy, tx_status, ilv_on, irq;
  logic [7:0] status_byte, tx_byte, hshk, reply;
  logic [7:0] sect_buf [BUF_DEPTH];

  // All pins pass the three-flop filter together.
  assign pins_raw = {i_addr, i_dbo, i_sout, i_sinp, i_pwr_n, i_pdbin,
                     i_poc_n, i_slave_clr_n, i_base_sw, i_prio_sel,
                     i_reset_source_jumper, i_write_qualify_jumper,
                     i_read_qualify_jumper, i_sector_size_strap};

  pin_sync #(.WIDTH(SW)) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_raw(pins_raw),
    .o_clean(pins)
  );

  assign {addr, dbo, sout, sinp, pwr_n, pdbin, poc_n, slave_clr_n, base_sw,
          prio, rs_jmp, wq_jmp, rq_jmp, ss_strap} = pins;

  // An all-closed switch bank means base zero, which is not decoded.
  assign hit = (base_sw != BASE_NONE) && (addr[7:2] == base_sw);
  assign wr_q = sout && (wq_jmp ? !pwr_n : 1'b1);
  assign rd_q = sinp && (rq_jmp ? pdbin : 1'b1);
  assign wr_hit = wr_q && hit;
  assign rd_hit = rd_q && hit;

  // A host cycle acts at its end, using the byte seen while it was held.
  // With status-only qualification the data bus may settle late, so the
  // last sample before the output status falls is the one that counts.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_act <= 1'b0;
      rd_act <= 1'b0;
      wr_ofs <= 2'h0;
      rd_ofs <= 2'h0;
      wr_data <= 8'h00;
    end else begin
      wr_act <= wr_hit;
      rd_act <= rd_hit;
      if (wr_hit) begin
        wr_ofs <= addr[1:0];
        wr_data <= dbo;
      end
      if (rd_hit) begin
        rd_ofs <= addr[1:0];
      end
    end
  end

  assign wr_evt = wr_act && !wr_hit;
  assign rd_evt = rd_act && !rd_hit;
  assign data_wr = wr_evt && (wr_ofs == OFS_DATA);
  assign start_wr = wr_evt && (wr_ofs == OFS_HSHK);
  assign data_rd = rd_evt && (rd_ofs == OFS_DATA);

  // Clear sources: jumper-selected bus clear plus the offset two write.
  assign hw_clr = rs_jmp ? !slave_clr_n : !poc_n;
  assign core_clr = hw_clr || soft_clr;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      soft_clr <= 1'b0;
    end else begin
      soft_clr <= wr_evt && (wr_ofs == OFS_CLEAR);
    end
  end

  // Interrupt enables.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ien <= IEN_RST;
    end else if (core_clr) begin
      ien <= IEN_RST;
    end else if (wr_evt && (wr_ofs == OFS_IEN)) begin
      ien <= wr_data[1:0];
    end
  end

  // Geometry follows the strap; long transfers add the check bytes.
  assign sect_len = ss_strap ? SECT_SMALL : SECT_LARGE;
  assign spt = ss_strap ? SPT_SMALL : SPT_LARGE;
  assign busy = (state == ST_EXEC) || (state == ST_RX) || (state == ST_TX);

  // Controller sequence: idle, command bytes, host data in, execute,
  // host data out. Ready flags drop on each byte and return a cycle later.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      cnt <= 10'h000;
      xfer_len <= 10'h000;
      exec_cnt <= 16'h0000;
      cmd_code <= 4'h0;
      out_rdy <= 1'b0;
      in_rdy <= 1'b0;
      tx_status <= 1'b0;
      ilv_on <= 1'b0;
      status_byte <= STAT_OK;
    end else if (core_clr) begin
      state <= ST_IDLE;
      cnt <= 10'h000;
      out_rdy <= 1'b0;
      in_rdy <= 1'b0;
      tx_status <= 1'b0;
      ilv_on <= 1'b0;
      status_byte <= STAT_OK;
    end else begin
      case (state)
        ST_IDLE: begin
          out_rdy <= 1'b0;
          in_rdy <= 1'b0;
          if (start_wr) begin
            state <= ST_CMD;
            cnt <= 10'h000;
            out_rdy <= 1'b1;
          end
        end
        ST_CMD: begin
          if (data_wr) begin
            out_rdy <= 1'b0;
            cnt <= cnt + 10'h001;
            if (cnt == 10'h000) begin
              cmd_code <= wr_data[3:0];
            end
            if (cnt == CMD_LAST_IDX) begin
              cnt <= 10'h000;
              exec_cnt <= 16'h0000;
              case (cmd_code)
                CMD_WRITE, CMD_WRITE_ALT: begin
                  state <= ST_RX;
                  xfer_len <= sect_len;
                end
                CMD_WRITE_LONG: begin
                  state <= ST_RX;
                  xfer_len <= sect_len + ECC_LEN;
                end
                CMD_SET_ILV: begin
                  state <= ST_RX;
                  xfer_len <= spt;
                end
                default: begin
                  state <= ST_EXEC;
                end
              endcase
            end
          end else if (!out_rdy) begin
            out_rdy <= 1'b1;
          end
        end
        ST_RX: begin
          if (data_wr) begin
            out_rdy <= 1'b0;
            cnt <= cnt + 10'h001;
            if (cnt == xfer_len - 10'h001) begin
              state <= ST_EXEC;
              cnt <= 10'h000;
            end
          end else if (!out_rdy) begin
            out_rdy <= 1'b1;
          end
        end
        ST_EXEC: begin
          out_rdy <= 1'b0;
          exec_cnt <= exec_cnt + 16'h0001;
          if (exec_cnt == EXEC_LAST) begin
            state <= ST_IDLE;
            tx_status <= 1'b0;
            status_byte <= STAT_OK;
            case (cmd_code)
              CMD_READ: begin
                state <= ST_TX;
                xfer_len <= sect_len;
                in_rdy <= 1'b1;
              end
              CMD_READ_LONG: begin
                state <= ST_TX;
                xfer_len <= sect_len + ECC_LEN;
                in_rdy <= 1'b1;
              end
              CMD_STATUS: begin
                state <= ST_TX;
                xfer_len <= 10'h001;
                tx_status <= 1'b1;
                in_rdy <= 1'b1;
                status_byte <= status_byte;
              end
              CMD_SET_ILV: begin
                ilv_on <= 1'b1;
              end
              CMD_DIAG: begin
                ilv_on <= 1'b0;
              end
              default: begin
                if (cmd_code > CMD_LAST) begin
                  status_byte <= STAT_BAD_CMD;
                end
              end
            endcase
          end
        end
        ST_TX: begin
          if (data_rd) begin
            in_rdy <= 1'b0;
            cnt <= cnt + 10'h001;
            if (cnt == xfer_len - 10'h001) begin
              state <= ST_IDLE;
              cnt <= 10'h000;
            end
          end else if (!in_rdy) begin
            in_rdy <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Sector buffer; the interleave table lands in it too.
  always_ff @(posedge i_mclk) begin
    if ((state == ST_RX) && data_wr) begin
      sect_buf[cnt] <= wr_data;
    end
    tx_byte <= sect_buf[cnt];
  end

  // Read reply: status or data at offset zero, handshake at offset one.
  always_comb begin
    hshk = 8'h00;
    hshk[HS_OUT_RDY_BIT] = out_rdy;
    hshk[HS_IN_RDY_BIT] = in_rdy;
    hshk[HS_BUSY_BIT] = busy;
    reply = status_byte;
    reply[STAT_ILV_BIT] = ilv_on;
  end

  // Data bus drive only while a qualified read hits offsets zero or one.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_dbi <= 8'h00;
      o_dbi_oe <= 1'b0;
    end else begin
      o_dbi_oe <= rd_hit && !addr[1];
      if (addr[0]) begin
        o_dbi <= hshk;
      end else begin
        o_dbi <= tx_status ? reply : tx_byte;
      end
    end
  end

  // The interrupt is level: it falls only when its cause or enable goes.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      irq <= 1'b0;
      o_vint_oe <= 8'h00;
    end else begin
      irq <= (ien[IEN_RX_BIT] && in_rdy)
          || (ien[IEN_DONE_BIT] && !busy);
      o_vint_oe <= irq ? 8'(8'h01 << prio) : 8'h00;
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  ien_cleared_a: assert property (
    core_clr |=> (ien == IEN_RST) && !out_rdy && !in_rdy ##1 !irq)
    else $error("enables survived a clear");
  one_line_a: assert property (
    irq |=> $onehot(o_vint_oe) && o_vint_oe[$past(prio)])
    else $error("wrong interrupt line");
  quiet_lines_a: assert property (
    (ien == IEN_RST) [*2] |=> (o_vint_oe == 8'h00))
    else $error("interrupt without enable");
  done_irq_a: assert property (
    ien[IEN_DONE_BIT] && !busy && !core_clr |=> irq ##1 (o_vint_oe != 8'h00))
    else $error("completion interrupt missing");
  rx_irq_a: assert property (
    ien[IEN_RX_BIT] && in_rdy && !core_clr |=> irq)
    else $error("receive interrupt missing");
  start_busy_a: assert property (
    busy && start_wr && !core_clr |=> (state != ST_CMD))
    else $error("start accepted while busy");
  cmd_len_a: assert property (
    (state == ST_CMD) && data_wr && (cnt == CMD_LAST_IDX) && !core_clr
    |=> busy && (cnt == 10'h000))
    else $error("command not closed at eighth byte");
  out_drop_a: assert property (
    data_wr && busy && !core_clr |=> !out_rdy)
    else $error("output ready not dropped");
  soft_clr_a: assert property (
    wr_evt && (wr_ofs == OFS_CLEAR) |=> soft_clr ##1 (state == ST_IDLE))
    else $error("soft clear missed");
  read_drive_a: assert property (
    o_dbi_oe |-> $past(rd_hit))
    else $error("data bus driven without read");
  idle_cmd_a: assert property (
    (state == ST_CMD) |-> !busy && !o_dbi[HS_BUSY_BIT] || !o_dbi_oe)
    else $error("busy while collecting command");

  cmd_start_c: cover property (start_wr && (state == ST_IDLE));
  status_c: cover property (data_rd && tx_status);
  rx_done_c: cover property ((state == ST_RX) ##1 (state == ST_EXEC));
  vint_c: cover property (o_vint_oe != 8'h00);
endmodule

// file: inc/disk_port_pkg.sv
/*
  Shared constants for the disk controller host byte port: port offsets,
  handshake and enable bit positions, sector geometry, command codes and
  the controller state type.
  Assumes nothing of its surroundings; imported by the port design.
*/
package disk_port_pkg;
  // Port offsets from the switch-selected base address.
  localparam logic [1:0] OFS_DATA = 2'h0;
  localparam logic [1:0] OFS_HSHK = 2'h1;
  localparam logic [1:0] OFS_CLEAR = 2'h2;
  localparam logic [1:0] OFS_IEN = 2'h3;
  // Handshake byte and interrupt enable bit positions.
  localparam int HS_OUT_RDY_BIT = 0;
  localparam int HS_IN_RDY_BIT = 1;
  localparam int HS_BUSY_BIT = 7;
  localparam int IEN_DONE_BIT = 0;
  localparam int IEN_RX_BIT = 1;
  localparam logic [1:0] IEN_RST = 2'h0;
  // Status byte values; the interleave flag is folded into the reply.
  localparam logic [7:0] STAT_OK = 8'h00;
  localparam logic [7:0] STAT_BAD_CMD = 8'h01;
  localparam int STAT_ILV_BIT = 6;
  // Command framing and sector geometry.
  localparam logic [9:0] CMD_LAST_IDX = 10'h007;
  localparam logic [9:0] SECT_SMALL = 10'h100;
  localparam logic [9:0] SECT_LARGE = 10'h200;
  localparam logic [9:0] SPT_SMALL = 10'h020;
  localparam logic [9:0] SPT_LARGE = 10'h011;
  localparam logic [9:0] ECC_LEN = 10'h004;
  localparam int BUF_DEPTH = 516;
  localparam logic [5:0] BASE_NONE = 6'h00;
  localparam int EXEC_CYCLES_DEF = 16;
  // Command codes.
  localparam logic [3:0] CMD_READ = 4'h1;
  localparam logic [3:0] CMD_WRITE = 4'h2;
  localparam logic [3:0] CMD_STATUS = 4'h5;
  localparam logic [3:0] CMD_READ_LONG = 4'h6;
  localparam logic [3:0] CMD_WRITE_LONG = 4'h7;
  localparam logic [3:0] CMD_WRITE_ALT = 4'h8;
  localparam logic [3:0] CMD_SET_ILV = 4'h9;
  localparam logic [3:0] CMD_DIAG = 4'hB;
  localparam logic [3:0] CMD_LAST = 4'hB;
  // Controller states.
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_EXEC, ST_RX, ST_TX
  } ctl_state_type;
endpackage

// file: hw/pin_sync.sv
/*
  Three-flop input synchroniser with agreement filter for a pin vector.
  Assumes every input bit is asynchronous to i_mclk.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // Raw pins in, filtered levels out.
  input wire logic [WIDTH-1:0] i_raw,
  output logic [WIDTH-1:0] o_clean
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] differ;

  // Stage one feeds only stage two, so no logic sees a metastable bit.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= i_raw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign differ = s2 ^ s3;

  // Each bit follows only once stages two and three agree.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_clean <= '0;
    end else begin
      o_clean <= (o_clean & differ) | (s2 & ~differ);
    end
  end
endmodule

// file: verif/host_model.sv
/*
  Host processor model for the disk port: runs I/O read and write cycles
  on the bus status, strobe, address and data pins.
  Assumes the port's clock; the bench calls its tasks by hierarchy.
*/
`timescale 1ns/10ps
module host_model (
  // Clock and read side of the port.
  input wire logic i_mclk,
  input wire logic [7:0] i_dbi,
  input wire logic i_dbi_oe,
  // Bus cycle pins.
  output logic [7:0] o_addr,
  output logic [7:0] o_dbo,
  output logic o_sout,
  output logic o_sinp,
  output logic o_pwr_n,
  output logic o_pdbin
);
  // Idle bus; data starts as a pattern so no settled zero can pass.
  initial begin
    o_addr = 8'hFF;
    o_dbo = 8'h5A;
    o_sout = 1'h0;
    o_sinp = 1'h0;
    o_pwr_n = 1'h1;
    o_pdbin = 1'h0;
  end

  // One bus cycle held eight edges, since the port filters every pin.
  // The answer settles by the fifth held rising edge and is taken at the
  // falling edge after the eighth, so it never races the port's own register update.
  task automatic cyc(input logic [7:0] a, input logic [7:0] d,
    input bit wr, input bit st, output logic [7:0] q, output logic oe);
    @(negedge i_mclk);
    o_addr = a;
    o_dbo = d;
    o_sout = wr;
    o_sinp = !wr;
    o_pwr_n = !(wr && st);
    o_pdbin = !wr && st;
    repeat (8) @(posedge i_mclk);
    @(negedge i_mclk);
    q = i_dbi;
    oe = i_dbi_oe;
    o_sout = 1'h0;
    o_sinp = 1'h0;
    o_pwr_n = 1'h1;
    o_pdbin = 1'h0;
    @(negedge i_mclk);
    o_dbo = ~d; // Released lines show no stale value.
    o_addr = ~a;
    repeat (6) @(negedge i_mclk);
  endtask

  // Polls the handshake byte until bit b reads v, at most 300 reads.
  task automatic wait_hs(input logic [7:0] a, input int b,
    input logic v, output bit ok);
    logic [7:0] q;
    logic oe;
    ok = 1'b0;
    for (int n = 0; n < 300 && !ok; n++) begin
      cyc(a, 8'h00, 1'b0, 1'b1, q, oe);
      ok = (q[b] === v);
    end
  endtask
endmodule

// file: verif/test_disk_ctrl_host_io_port.sv
/*
  Self-checking bench for the disk host port: commands, sector loopback,
  interleave, interrupts, decode, strobe qualification and clear sources.
  Assumes host_model on the bus pins and a short execute count.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  failures++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_disk_ctrl_host_io_port;
  import disk_port_pkg::*;
  logic i_mclk, i_rst, i_poc_n, i_slave_clr_n;
  logic [5:0] i_base_sw;
  logic [2:0] i_prio_sel;
  logic rsj, wqj, rqj, strap;
  logic [7:0] addr, dbo, o_dbi, o_vint_oe, q;
  logic sout, sinp, pwr_n, pdbin, o_dbi_oe, oe;
  logic [7:0] base = 8'h80;
  bit ok;
  int failures = 0;
  int n_checks = 0;

  disk_ctrl_host_io_port #(.EXEC_CYCLES(4)) DUT (.i_mclk(i_mclk),
    .i_rst(i_rst), .i_addr(addr), .i_dbo(dbo), .i_sout(sout),
    .i_sinp(sinp), .i_pwr_n(pwr_n), .i_pdbin(pdbin), .i_poc_n(i_poc_n),
    .i_slave_clr_n(i_slave_clr_n), .i_base_sw(i_base_sw),
    .i_prio_sel(i_prio_sel), .i_reset_source_jumper(rsj),
    .i_write_qualify_jumper(wqj), .i_read_qualify_jumper(rqj),
    .i_sector_size_strap(strap), .o_dbi(o_dbi), .o_dbi_oe(o_dbi_oe),
    .o_vint_oe(o_vint_oe));
  host_model HOST (.i_mclk(i_mclk), .i_dbi(o_dbi), .i_dbi_oe(o_dbi_oe),
    .o_addr(addr), .o_dbo(dbo), .o_sout(sout), .o_sinp(sinp),
    .o_pwr_n(pwr_n), .o_pdbin(pdbin));

  // Free-running 40 MHz clock.
  initial begin
    i_mclk = 1'h0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic settle();
    repeat (6) @(negedge i_mclk);
  endtask
  task automatic wr(input logic [1:0] o, input logic [7:0] d);
    HOST.cyc(base | {6'h00, o}, d, 1'b1, 1'b1, q, oe);
  endtask
  task automatic rd(input logic [1:0] o);
    HOST.cyc(base | {6'h00, o}, 8'h00, 1'b0, 1'b1, q, oe);
  endtask
  // A handshake wait that runs out ends the run as a mismatch.
  task automatic hs(input int b, input logic v);
    HOST.wait_hs(base | 8'h01, b, v, ok);
    if (!ok) begin
      failures++;
      final_report();
    end
  endtask
  task automatic cmd(input logic [3:0] c);
    hs(HS_BUSY_BIT, 1'b0);
    wr(OFS_HSHK, 8'h00);
    for (int i = 0; i < 8; i++) begin
      hs(HS_OUT_RDY_BIT, 1'b1);
      wr(OFS_DATA, i == 0 ? {4'h0, c} : 8'hA5); // Pads.
    end
  endtask
  task automatic put(input logic [7:0] d);
    hs(HS_OUT_RDY_BIT, 1'b1);
    wr(OFS_DATA, d);
  endtask
  task automatic get();
    hs(HS_IN_RDY_BIT, 1'b1);
    rd(OFS_DATA);
  endtask
  task automatic status(input logic [7:0] e);
    cmd(CMD_STATUS);
    get();
    `CHK("status", e, q)
    hs(HS_BUSY_BIT, 1'b0);
  endtask
  // Loads an interleave table; a wrong table length hangs on busy.
  task automatic ilv();
    cmd(CMD_SET_ILV);
    for (int i = 0; i < 17; i++) put(8'(i));
    hs(HS_BUSY_BIT, 1'b0);
  endtask
  task automatic pulse(input bit slv);
    if (slv) i_slave_clr_n = 1'h0;
    else i_poc_n = 1'h0;
    repeat (10) @(negedge i_mclk);
    i_slave_clr_n = 1'h1;
    i_poc_n = 1'h1;
    repeat (10) @(negedge i_mclk);
  endtask

  task automatic t_reset();
    rd(OFS_HSHK);
    `CHK("hshk", 8'h00, q & 8'h83)
    `CHK("vint", 8'h00, o_vint_oe)
  endtask
  task automatic t_ilv();
    ilv();
    status(8'h40);
    cmd(CMD_DIAG);
    status(8'h00);
    cmd(4'hC);
    status(8'h01);
    ilv();
    wr(OFS_CLEAR, 8'h00);
    status(8'h00);
    ilv();
    status(8'h40);
  endtask
  // Sector write with a start attempt mid-transfer, then read back.
  task automatic t_sector(input bit s);
    int n;
    n = s ? 256 : 512;
    strap = s;
    cmd(CMD_WRITE);
    for (int i = 0; i < n; i++) begin
      put(8'(i) ^ 8'h3C);
      if (i == 100) begin
        rd(OFS_HSHK);
        `CHK("busy", 1'b1, q[HS_BUSY_BIT])
        wr(OFS_HSHK, 8'h00);
      end
    end
    cmd(CMD_READ);
    for (int i = 0; i < n; i++) begin
      get();
      `CHK("data", 8'(i) ^ 8'h3C, q)
    end
    hs(HS_BUSY_BIT, 1'b0);
    rd(OFS_HSHK);
    `CHK("in_rdy", 1'b0, q[HS_IN_RDY_BIT])
  endtask
  task automatic t_irq();
    wr(OFS_IEN, 8'h01);
    `CHK("vint", 8'h20, o_vint_oe)
    for (int p = 0; p < 8; p++) begin
      i_prio_sel = 3'(p);
      settle();
      `CHK("vint", 8'h01 << p, o_vint_oe)
    end
    i_prio_sel = 3'h5;
    wr(OFS_IEN, 8'h00);
    `CHK("vint", 8'h00, o_vint_oe)
    cmd(CMD_STATUS);
    hs(HS_IN_RDY_BIT, 1'b1);
    wr(OFS_IEN, 8'h02);
    `CHK("vint", 8'h20, o_vint_oe)
    get();
    hs(HS_BUSY_BIT, 1'b0);
    `CHK("vint", 8'h00, o_vint_oe)
    wr(OFS_IEN, 8'h03);
    `CHK("vint", 8'h20, o_vint_oe)
    wr(OFS_CLEAR, 8'h00);
    settle(); // The clear takes one cycle more than a plain enable write.
    `CHK("vint", 8'h00, o_vint_oe)
  endtask
  // Strobe-less cycles count only with the status-only jumper setting.
  task automatic t_qual();
    for (int j = 0; j < 2; j++) begin
      wqj = 1'(j);
      rqj = 1'(j);
      settle();
      HOST.cyc(base | 8'h03, 8'h01, 1'b1, 1'b0, q, oe);
      `CHK("vint", j == 0 ? 8'h20 : 8'h00, o_vint_oe)
      wr(OFS_IEN, 8'h00);
      HOST.cyc(base | 8'h01, 8'h00, 1'b0, 1'b0, q, oe);
      `CHK("dbi_oe", j == 0, oe)
      rd(OFS_HSHK);
      `CHK("dbi_oe", 1'b1, oe)
    end
    wqj = 1'h0;
    rqj = 1'h0;
  endtask
  task automatic t_src();
    for (int j = 1; j >= 0; j--) begin
      rsj = 1'(j);
      wr(OFS_IEN, 8'h01);
      pulse(1'b1);
      `CHK("vint", j == 1 ? 8'h00 : 8'h20, o_vint_oe)
    end
    pulse(1'b0);
    `CHK("vint", 8'h00, o_vint_oe)
  endtask
  task automatic t_decode();
    HOST.cyc(8'h43, 8'h01, 1'b1, 1'b1, q, oe);
    `CHK("vint", 8'h00, o_vint_oe)
    i_base_sw = 6'h3F;
    base = 8'hFC;
    settle();
    wr(OFS_IEN, 8'h01);
    `CHK("vint", 8'h20, o_vint_oe)
    HOST.cyc(8'h83, 8'h00, 1'b1, 1'b1, q, oe);
    `CHK("vint", 8'h20, o_vint_oe)
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    i_rst = 1'h1;
    i_poc_n = 1'h1;
    i_slave_clr_n = 1'h1;
    i_base_sw = 6'h20;
    i_prio_sel = 3'h5;
    rsj = 1'h0;
    wqj = 1'h0;
    rqj = 1'h0;
    strap = 1'h0;
    repeat (8) @(negedge i_mclk);
    i_rst = 1'h0;
    repeat (10) @(negedge i_mclk);
    t_reset();
    t_ilv();
    t_sector(1'b1);
    t_sector(1'b0);
    t_irq();
    t_qual();
    t_src();
    t_decode();
    final_report();
  end
endmodule
